//--- design/ssl_consts.svh
`ifndef SSL_CONSTS_SVH
`define SSL_CONSTS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SSL_CLK_PERIOD_NS   8
`define SSL_STRAP_WIN_MS    500
`define SSL_RED_VALID_MS    600
// cycles from the millisecond times at 8 ns per cycle
`define SSL_STRAP_WIN_CYC   \
  ((`SSL_STRAP_WIN_MS * 1000000) / `SSL_CLK_PERIOD_NS)
`define SSL_RED_VALID_CYC   \
  ((`SSL_RED_VALID_MS * 1000000) / `SSL_CLK_PERIOD_NS)
// activity flash half period in cycles
`define SSL_FLASH_HALF_CYC  16'h3000
// restore request codes
`define SSL_RST_NONE        2'h0
`define SSL_RST_SERIAL      2'h1
`define SSL_RST_FACTORY     2'h2

`endif

//--- design/ssl_pkg.sv
package ssl_pkg;

  // start-up phases, one-hot
  typedef enum logic [2:0] {
    SSL_ST_STRAP = 3'h1,
    SSL_ST_GREEN = 3'h2,
    SSL_ST_RUN   = 3'h4
  } ssl_state_t;

  // indicator request from the core
  typedef struct packed {
    logic red;
    logic green;
    logic busy;
  } ssl_ind_t;

  // restore requests to the core
  typedef struct packed {
    logic serial;
    logic factory;
  } ssl_restore_t;

endpackage : ssl_pkg

//--- design/ssl_strap_led.sv
// Notes on behaviour
// R1 - red indicator drives active low, valid from 600 ms after power-up
// R2 - function input has weak pull-up; low requests connect-on-signal
// R3 - function input low at start-up restores factory defaults
// R4 - green indicator drives active low, valid from 500 ms
// R5 - shared green pin sampled only in first 500 ms, ignored after
// R6 - after the input window the shared pin becomes the green output
// R7 - shared pin low in the window restores serial defaults
// R8 - shared pin active low as input, weak pull-up when undriven
// R9 - both inputs low at power-up restores every factory setting
// R10 - activity indicator drives active low showing status
// R11 - activity indicator flashes while data is transferred
// R12 - both requests together give factory restore, not serial only
`include "ssl_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ssl_strap_led
  import ssl_pkg::*;
#(
  parameter int unsigned STRAP_WIN_CYC = `SSL_STRAP_WIN_CYC,
  parameter int unsigned RED_VALID_CYC = `SSL_RED_VALID_CYC
) (
  input  wire logic     CORE_CLK,
  input  wire logic     RESET,
  input  wire logic     FUNC_IN_N,
  input  wire logic     GREEN_STRAP_IN,
  input  wire ssl_ind_t IND_REQ,
  output var  logic     GREEN_STRAP_OUT,
  output var  logic     GREEN_STRAP_OE,
  output var  logic     GREEN_STRAP_PULLUP,
  output var  logic     FUNC_PULLUP,
  output var  logic     RED_N,
  output var  logic     ACTIVITY_N,
  output var  logic     CONNECT_REQ,
  output var  logic     RESTORE_SERIAL,
  output var  logic     RESTORE_FACTORY,
  output var  logic     STRAP_DONE
);

  // ----------------------------------------------------------------
  // power-up timer
  // ----------------------------------------------------------------
  logic [31:0] up_cnt;
  ssl_state_t  state;
  ssl_state_t  next_state;
  logic        win_end;
  logic        red_ok;

  assign win_end = (up_cnt == 32'(STRAP_WIN_CYC - 1));
  assign red_ok  = (up_cnt >= 32'(RED_VALID_CYC - 1));

  // counts until red is valid, then stops so it never wraps
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      up_cnt <= 32'h0;
    end else if (!red_ok) begin
      up_cnt <= up_cnt + 32'h1;
    end
  end

  // phase sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      SSL_ST_STRAP: begin
        if (win_end) next_state = SSL_ST_GREEN;
      end
      SSL_ST_GREEN: begin
        if (red_ok) next_state = SSL_ST_RUN;
      end
      SSL_ST_RUN: begin
        next_state = SSL_ST_RUN;
      end
      default: next_state = SSL_ST_STRAP;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state <= SSL_ST_STRAP;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // strap sampling
  // ----------------------------------------------------------------
  // a strap seen low at any point in the window latches; a bouncing
  // switch therefore still counts, at the cost of glitch immunity
  logic func_seen;
  logic green_seen;
  logic func_any;
  logic green_any;
  logic in_win;

  assign in_win = (state == SSL_ST_STRAP);

  // the closing edge's own sample counts too, so no window cycle is lost
  assign func_any  = func_seen || !FUNC_IN_N;
  assign green_any = green_seen || !GREEN_STRAP_IN;

  // R5 window-only sample
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      func_seen  <= 1'b0;
      green_seen <= 1'b0;
    end else if (in_win) begin
      // R3 function strap low
      if (!FUNC_IN_N) func_seen <= 1'b1;
      // R8 active-low input
      if (!GREEN_STRAP_IN) green_seen <= 1'b1;
    end
  end

  // one restore pulse at window end; factory takes precedence
  ssl_restore_t rst_req;
  always_comb begin
    rst_req = '0;
    // R9 both low, full restore
    // R12 factory replaces serial
    if (func_any) begin
      rst_req.factory = 1'b1;
    // R7 serial-only restore
    end else if (green_any) begin
      rst_req.serial = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      RESTORE_SERIAL  <= 1'b0;
      RESTORE_FACTORY <= 1'b0;
    end else begin
      RESTORE_SERIAL  <= win_end && in_win && rst_req.serial;
      RESTORE_FACTORY <= win_end && in_win && rst_req.factory;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      STRAP_DONE <= 1'b0;
    end else if (win_end && in_win) begin
      STRAP_DONE <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pull-ups and function request
  // ----------------------------------------------------------------
  // R2 pull-up and request
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      FUNC_PULLUP <= 1'b1;
      CONNECT_REQ <= 1'b0;
    end else begin
      FUNC_PULLUP <= 1'b1;
      CONNECT_REQ <= !in_win && !FUNC_IN_N;
    end
  end

  // ----------------------------------------------------------------
  // indicators
  // ----------------------------------------------------------------
  // R6 pin turns to output
  // R4 green active low
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      GREEN_STRAP_OE     <= 1'b0;
      GREEN_STRAP_OUT    <= 1'b1;
      GREEN_STRAP_PULLUP <= 1'b1;
    end else begin
      GREEN_STRAP_OE     <= !in_win || win_end;
      GREEN_STRAP_OUT    <= !(IND_REQ.green && !in_win);
      // R8 pull-up while input
      GREEN_STRAP_PULLUP <= in_win && !win_end;
    end
  end

  // R1 red valid late
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      RED_N <= 1'b1;
    end else begin
      RED_N <= !(IND_REQ.red && state == SSL_ST_RUN);
    end
  end

  // flash timer, free while busy
  logic [15:0] flash_cnt;
  logic        flash_ph;
  always_ff @(posedge CORE_CLK) begin
    if (RESET || !IND_REQ.busy) begin
      flash_cnt <= 16'h0;
      flash_ph  <= 1'b0;
    end else if (flash_cnt == `SSL_FLASH_HALF_CYC - 16'h1) begin
      flash_cnt <= 16'h0;
      flash_ph  <= !flash_ph;
    end else begin
      flash_cnt <= flash_cnt + 16'h1;
    end
  end

  // R10 active-low activity
  // R11 flash on transfer
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ACTIVITY_N <= 1'b1;
    end else begin
      ACTIVITY_N <= !(IND_REQ.busy && !flash_ph);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_window_close;
    in_win && win_end;
  endsequence

  property p_red_quiet;
    @(posedge CORE_CLK) disable iff (RESET)
      (state != SSL_ST_RUN) |=> RED_N;
  endproperty
  a_red_quiet: assert property (p_red_quiet) // R1
    else $error("red active before valid time");

  property p_pullup;
    @(posedge CORE_CLK) disable iff (RESET) ##1 FUNC_PULLUP;
  endproperty
  a_pullup: assert property (p_pullup) // R2
    else $error("function pull-up dropped");

  property p_factory;
    @(posedge CORE_CLK) disable iff (RESET)
      s_window_close ##0 func_any |=> RESTORE_FACTORY && !RESTORE_SERIAL;
  endproperty
  a_factory: assert property (p_factory) // R3
    else $error("factory restore missing");

  property p_green_quiet;
    @(posedge CORE_CLK) disable iff (RESET)
      in_win && !win_end |=> GREEN_STRAP_OUT && !GREEN_STRAP_OE;
  endproperty
  a_green_quiet: assert property (p_green_quiet) // R4
    else $error("green driven inside window");

  property p_ignore_late;
    @(posedge CORE_CLK) disable iff (RESET)
      !in_win |=> $stable(green_seen) && $stable(func_seen);
  endproperty
  a_ignore_late: assert property (p_ignore_late) // R5
    else $error("strap sampled after window");

  property p_turn_out;
    @(posedge CORE_CLK) disable iff (RESET)
      s_window_close |=> GREEN_STRAP_OE ##1 GREEN_STRAP_OE;
  endproperty
  a_turn_out: assert property (p_turn_out) // R6
    else $error("shared pin not turned to output");

  property p_serial;
    @(posedge CORE_CLK) disable iff (RESET)
      s_window_close ##0 (green_any && !func_any) |=> RESTORE_SERIAL;
  endproperty
  a_serial: assert property (p_serial) // R7
    else $error("serial restore missing");

  property p_only_once;
    @(posedge CORE_CLK) disable iff (RESET)
      RESTORE_FACTORY || RESTORE_SERIAL |=>
        !RESTORE_FACTORY && !RESTORE_SERIAL;
  endproperty
  a_only_once: assert property (p_only_once) // single-cycle restore pulse
    else $error("restore pulse longer than one cycle");

  property p_idle_act;
    @(posedge CORE_CLK) disable iff (RESET)
      !IND_REQ.busy |=> ACTIVITY_N;
  endproperty
  a_idle_act: assert property (p_idle_act) // R10
    else $error("activity lit while idle");

  property p_red_follow;
    @(posedge CORE_CLK) disable iff (RESET)
      (state == SSL_ST_RUN) |=> RED_N == !$past(IND_REQ.red);
  endproperty
  a_red_follow: assert property (p_red_follow) // R1
    else $error("red does not follow its request");

  property p_connect;
    @(posedge CORE_CLK) disable iff (RESET)
      !in_win && !FUNC_IN_N |=> CONNECT_REQ;
  endproperty
  a_connect: assert property (p_connect) // R2
    else $error("connect request missing");

  property p_green_follow;
    @(posedge CORE_CLK) disable iff (RESET)
      !in_win |=> GREEN_STRAP_OUT == !$past(IND_REQ.green);
  endproperty
  a_green_follow: assert property (p_green_follow) // R4
    else $error("green does not follow its request");

  property p_pullup_win;
    @(posedge CORE_CLK) disable iff (RESET)
      in_win && !win_end |=> GREEN_STRAP_PULLUP;
  endproperty
  a_pullup_win: assert property (p_pullup_win) // R8
    else $error("shared pin pull-up off inside window");

  property p_flash_dark;
    @(posedge CORE_CLK) disable iff (RESET)
      IND_REQ.busy && flash_ph |=> ACTIVITY_N;
  endproperty
  a_flash_dark: assert property (p_flash_dark) // R11
    else $error("activity not dark in off phase");

endmodule : ssl_strap_led

`default_nettype wire

//--- test/ssl_board.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// carrier board: switches and pin levels
// ----------------------------------------
module ssl_board (
  input  wire logic clk,
  input  wire logic f_press,
  input  wire logic g_press,
  input  wire logic g_oe,
  input  wire logic g_out,
  input  wire logic g_pu,
  input  wire logic f_pu,
  output var  logic f_n,
  output var  logic g_n
);
  logic lf = 1'b0;
  logic lg = 1'b0;
  // floating lines flip each cycle so no stale level survives
  always @(posedge clk) begin
    lf <= f_n;
    lg <= g_n;
  end
  always_comb begin
    f_n = f_press ? 1'b0 : (f_pu ? 1'b1 : ~lf);
    if (g_oe) g_n = g_out & ~g_press;
    else g_n = g_press ? 1'b0 : (g_pu ? 1'b1 : ~lg);
  end
endmodule : ssl_board

`default_nettype wire

//--- test/ssl_strap_led_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssl_consts.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end

module ssl_strap_led_tb;
  import ssl_pkg::*;
  localparam int unsigned WIN = 20;
  localparam int unsigned RED = 30;
  logic     clk = 1'b0;
  logic     rst = 1'b1;
  logic     fp = 1'b0;
  logic     gp = 1'b0;
  ssl_ind_t req = '0;
  logic     f_n, g_n, g_out, g_oe, g_pu, f_pu, red_n, act_n;
  logic     conn, r_ser, r_fac, done;
  int       error_cnt = 0;
  int       checks = 0;
  int       seed = 99536;
  int       k, t;

  // expected {done, factory, serial} once the window has closed
  function automatic logic [2:0] exp_restore(input logic f, input logic g);
    // function low wins over the shared strap
    return {1'b1, f, g & ~f};
  endfunction : exp_restore

  always #4 clk = ~clk;

  ssl_board u_ssl_board (.clk(clk), .f_press(fp), .g_press(gp),
    .g_oe(g_oe), .g_out(g_out), .g_pu(g_pu), .f_pu(f_pu),
    .f_n(f_n), .g_n(g_n));

  ssl_strap_led #(.STRAP_WIN_CYC(WIN), .RED_VALID_CYC(RED))
    u_ssl_strap_led (.CORE_CLK(clk), .RESET(rst), .FUNC_IN_N(f_n),
    .GREEN_STRAP_IN(g_n), .IND_REQ(req), .GREEN_STRAP_OUT(g_out),
    .GREEN_STRAP_OE(g_oe), .GREEN_STRAP_PULLUP(g_pu), .FUNC_PULLUP(f_pu),
    .RED_N(red_n), .ACTIVITY_N(act_n), .CONNECT_REQ(conn),
    .RESTORE_SERIAL(r_ser), .RESTORE_FACTORY(r_fac), .STRAP_DONE(done));

  // one reset per run; a short press somewhere inside the window
  task automatic run(input logic f, input logic g);
    rst = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t = {$random(seed)} % (WIN - 2);
    for (k = 0; k < WIN - 1; k++) begin
      @(negedge clk);
      `CHK(g_oe, 1'b0)
      `CHK(g_pu, 1'b1)
      `CHK(f_pu, 1'b1)
      `CHK({done, conn, r_ser, r_fac}, 4'h0)
      `CHK({g_out, red_n, act_n}, 3'h7)
      fp = f && (k == t);
      gp = g && (k == t);
      req = ssl_ind_t'(3'($random(seed)) & 3'h6);
    end
    k = WIN - 2;
    while (done !== 1'b1 && k < WIN + 2) begin
      @(negedge clk);
      k++;
    end
    `CHK({done, r_fac, r_ser}, exp_restore(f, g))
    `CHK({g_oe, g_pu}, 2'h2)
    // inputs set here are sampled at the next rising edge and show
    // on the registered outputs by the following falling edge
    for (t = 0; k < RED + 8; k++) begin
      fp = 1'($random(seed));
      gp = 1'($random(seed));
      req = ssl_ind_t'(3'($random(seed)) & 3'h6);
      @(negedge clk);
      `CHK({r_ser, r_fac}, 2'h0)
      `CHK(g_out, ~req.green)
      `CHK(conn, fp)
      if (k + 1 < RED) `CHK(red_n, 1'b1)
      else `CHK(red_n, ~req.red)
    end
    fp = 1'b0;
    gp = 1'b0;
    req = '0;
    repeat (2) @(negedge clk);
    `CHK(act_n, 1'b1)
    req.busy = 1'b1;
    @(negedge clk);
    `CHK(act_n, 1'b0)
    req = '0;
  endtask : run

  task automatic final_report();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  initial begin
    for (int i = 0; i < 5; i++) run(i[1] | i[2], i[0]);
    // flash phase once only: a half period is long
    @(negedge clk);
    req.busy = 1'b1;
    repeat (`SSL_FLASH_HALF_CYC) @(negedge clk);
    `CHK(act_n, 1'b0)
    @(negedge clk);
    `CHK(act_n, 1'b1)
    req = '0;
    final_report();
  end

  // runs take a few hundred cycles, the flash check one half period more
  initial begin
    #150000;
    error_cnt++;
    final_report();
  end
endmodule : ssl_strap_led_tb

`default_nettype wire
